// file: design/cdd_regs.svh
// register offsets, field positions, reset values and constants of the divider block
`ifndef CDD_REGS_SVH
`define CDD_REGS_SVH
`define CDD_IDX_DELAYED_OUTPUT_FIRST_DELAY_BYPASS    9'h0a0
`define CDD_IDX_DELAYED_OUTPUT_FIRST_RAMP_SETUP      9'h0a1
`define CDD_IDX_DELAYED_OUTPUT_FIRST_DELAY_FRACTION  9'h0a2
`define CDD_IDX_OUT7_DELAY_BYPASS    9'h0a3
`define CDD_IDX_OUT7_RAMP_SETUP      9'h0a4
`define CDD_IDX_OUT7_DELAY_FRACTION  9'h0a5
`define CDD_IDX_OUT8_DELAY_BYPASS    9'h0a6
`define CDD_IDX_OUT8_RAMP_SETUP      9'h0a7
`define CDD_IDX_OUT8_DELAY_FRACTION  9'h0a8
`define CDD_IDX_DELAYED_OUTPUT_LAST_DELAY_BYPASS    9'h0a9
`define CDD_IDX_DELAYED_OUTPUT_LAST_RAMP_SETUP      9'h0aa
`define CDD_IDX_DELAYED_OUTPUT_LAST_DELAY_FRACTION  9'h0ab
`define CDD_IDX_CHAN_A_STAGE1_COUNTS 9'h199
`define CDD_IDX_CHAN_A_PHASE_CODES   9'h19a
`define CDD_IDX_CHAN_A_STAGE2_COUNTS 9'h19b
`define CDD_IDX_CHAN_A_START_HIGH    9'h19c
`define CDD_IDX_CHAN_B_STAGE1_COUNTS 9'h19e
`define CDD_IDX_CHAN_B_PHASE_CODES   9'h19f
`define CDD_IDX_CHAN_B_STAGE2_COUNTS 9'h1a0
`define CDD_IDX_CHAN_B_START_HIGH    9'h1a1
`define CDD_IDX_CTRL                 9'h1b0
`define CDD_IDX_STATUS               9'h1b1
// field positions
`define CDD_LOW_MSB        7
`define CDD_LOW_LSB        4
`define CDD_HIGH_MSB       3
`define CDD_HIGH_LSB       0
`define CDD_CAP_MSB        5
`define CDD_CAP_LSB        3
`define CDD_CUR_MSB        2
`define CDD_CUR_LSB        0
`define CDD_FRAC_MSB       5
`define CDD_CTRL_DCC_OFF   0
`define CDD_CTRL_BYP_BASE  1
`define CDD_CTRL_RESTART   5
// reset value and writable masks
`define CDD_RST_REG        8'h00
`define CDD_MASK_BYPASS    8'h01
`define CDD_MASK_SIX       8'h3f
`define CDD_MASK_SH        8'h03
`define CDD_MASK_FULL      8'hff
`define CDD_MASK_CTRL      8'h1f
// phase and fine delay arithmetic
`define CDD_PHASE_SPLIT    6'd16
`define CDD_RAMP_UNIT_UA   200
`define CDD_FRAC_FULL      63
`define CDD_FRAC_MAX       47
`define CDD_RANGE_GAIN_PS  265720
`define CDD_OFS_BASE_PS    340
`define CDD_OFS_REF_UA     1600
`define CDD_OFS_DIV        10
`define CDD_OFS_CAP_PS     6000
`endif

// file: design/cdd_pkg.sv
// state types of the cascaded divider block
package cdd_pkg;
   typedef struct packed {
      logic       waiting;
      logic       high;
      logic       extend;
      logic [3:0] cnt;
      logic [5:0] waitCnt;
   } cdd_stage_s;

   typedef struct packed {
      logic [11:0][7:0] fdReg;
      logic [7:0][7:0]  divReg;
      logic [4:0]       ctrl;
      logic             restart;
      logic             ack;
      logic [31:0]      rdata;
      logic             srcPrev;
      logic [1:0]       s1Prev;
      logic [1:0]       chanOut;
      logic [3:0]       outLvl;
      logic [3:0]       stopped;
      logic [3:0][15:0] fineDelay;
      logic [3:0][2:0]  capCount;
      logic [3:0][10:0] rampUa;
   } cdd_top_s;
endpackage

// file: design/cdd_stage.sv
// one divider stage with high/low counts, coarse phase delay and duty correction
`timescale 1ns/1ps
`include "cdd_regs.svh"
module cdd_stage (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       restart,
   input  wire logic       inRise,
   input  wire logic       inLevel,
   input  wire logic       bypass,
   input  wire logic       dccOn,
   input  wire logic [3:0] lowCode,
   input  wire logic [3:0] highCode,
   input  wire logic [3:0] phaseCode,
   input  wire logic       startHigh,
   output logic            outLevel
);
   cdd_pkg::cdd_stage_s st_reg;
   cdd_pkg::cdd_stage_s st_next;
   logic [5:0]          phaseVal;
   logic                oddDcc;

   // RQ4 five bit phase
   assign phaseVal = {1'b0, startHigh, phaseCode};
   // odd divide with low one above high
   assign oddDcc = dccOn & ({1'b0, lowCode} == ({1'b0, highCode} + 5'h01));

   // counting on each input rising edge
   always_comb
   begin
      st_next = st_reg;
      if (restart)
      begin
         st_next.waiting = 1'b1;
         st_next.high    = 1'b0;
         st_next.extend  = 1'b0;
         st_next.cnt     = highCode;
         // RQ5 coarse delay count
         if (phaseVal < `CDD_PHASE_SPLIT)
            st_next.waitCnt = phaseVal;
         else
            // low cycles are code plus one, then one period more
            st_next.waitCnt = phaseVal - `CDD_PHASE_SPLIT + {2'h0, lowCode} + 6'h02;
      end
      else if (inRise)
      begin
         st_next.extend = 1'b0;
         if (st_reg.waiting)
         begin
            if (st_reg.waitCnt == 6'h00)
            begin
               st_next.waiting = 1'b0;
               st_next.high    = 1'b1;
               st_next.cnt     = highCode;
            end
            else
               st_next.waitCnt = st_reg.waitCnt - 6'h01;
         end
         // RQ1 count codes plus one
         else if (st_reg.cnt != 4'h0)
            st_next.cnt = st_reg.cnt - 4'h1;
         else if (st_reg.high)
         begin
            st_next.high   = 1'b0;
            st_next.cnt    = lowCode;
            st_next.extend = 1'b1;
         end
         else
         begin
            st_next.high = 1'b1;
            st_next.cnt  = highCode;
         end
      end
   end

   // RQ13 bypass passes input
   // RQ7 half period duty fix
   assign outLevel = bypass ? inLevel :
                     st_reg.waiting ? startHigh :
                     (st_reg.high | (st_reg.extend & oddDcc & inLevel));

   // state register
   always_ff @(posedge clk)
   begin
      if (rst)
         st_reg <= '0;
      else if (ce)
         st_reg <= st_next;
   end
endmodule

// file: design/cdd_divider_top.sv
// two cascaded divider channels with coarse phase, fine delay settings and register bus
// Function
// RQ1 - high and low codes store cycles minus one; divide is sum plus two
// RQ2 - channel A stage 1 counts, phase code low nibble, start-high bit 0
// RQ3 - channel B same layout; stage 2 uses upper phase nibble, start-high bit 1
// RQ4 - phase value is start-high times 16 plus the 4-bit phase code
// RQ5 - phase up to 15 delays that many; else value minus 16 plus low count (the stage delays one period more)
// RQ6 - both stages bypassed gives input duty; 50% input gives 50% always (with duty fix off an odd divide keeps its uneven high/low counts)
// RQ7 - duty fix: even stage 1, or odd stage 1 then even stage 2, gives 50%
// RQ8 - each delayed output has capacitor, current, fraction fields and bypass bit
// RQ9 - capacitor count is number of zero bits in its field plus one
// RQ10 - ramp current 200 uA per step; delay is range times fraction/63 plus offset
// RQ11 - software keeps delay fraction codes at or below 47
// RQ12 - delay above half the output period stops the output toggling
// RQ13 - stage 2 runs from stage 1 output; bypassed stage passes its input
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "cdd_regs.svh"
module cdd_divider_top #(
   parameter int SRC_PERIOD_PS = 40000
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic              srcClk,
   input  wire logic [10:0]       address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   input  wire logic [3:0]        byteenable,
   output logic [31:0]            readdata,
   output logic                   waitrequest,
   output logic                   delayedOutputFirst,
   output logic                   delayedOutputSecond,
   output logic                   delayedOutputThird,
   output logic                   delayedOutputLast,
   output logic [3:0]             delayBypass,
   output logic [3:0][2:0]        capCount,
   output logic [3:0][10:0]       rampCurrentUa,
   output logic [3:0][15:0]       fineDelayPs
);
   localparam cdd_pkg::cdd_top_s RST_STATE = '{restart: 1'b1, default: '0};

   cdd_pkg::cdd_top_s st_reg;
   cdd_pkg::cdd_top_s st_next;
   logic [1:0]        s1Out;
   logic [1:0]        s2Out;
   logic [1:0]        s1Rise;
   logic              srcRise;
   logic              dccOn;
   logic [8:0]        idx;
   logic              isFd;
   logic              isDiv;
   logic [3:0]        fdSlot;
   logic [2:0]        divSlot;
   logic [7:0]        slotMask;
   logic [7:0]        readByte;

   // fine delay in ps from the three codes
   function automatic logic [15:0] calcDelay(
      input logic [2:0] capCode,
      input logic [2:0] curCode,
      input logic [5:0] frac
   );
      int caps;
      int iramp;
      int rng;
      int ofs;
      // RQ9 zero bits plus one
      caps = 1 + int'(!capCode[0]) + int'(!capCode[1]) + int'(!capCode[2]);
      // RQ10 ramp current steps
      iramp = `CDD_RAMP_UNIT_UA * (int'(curCode) + 1);
      rng = ((caps + 3) * `CDD_RANGE_GAIN_PS) / iramp;
      ofs = `CDD_OFS_BASE_PS + (`CDD_OFS_REF_UA - iramp) / `CDD_OFS_DIV
            + ((caps - 1) * `CDD_OFS_CAP_PS) / iramp;
      // RQ10 range times fraction
      return 16'((rng * int'(frac)) / `CDD_FRAC_FULL + ofs);
   endfunction

   // zero bit count plus one for the capacitor output
   function automatic logic [2:0] calcCaps(input logic [2:0] capCode);
      return 3'(1 + int'(!capCode[0]) + int'(!capCode[1]) + int'(!capCode[2]));
   endfunction

   // total divide of one stage, one when bypassed
   function automatic int stageDiv(input logic byp, input logic [7:0] counts);
      // RQ1 sum of codes plus two
      return byp ? 1 : int'(counts[`CDD_LOW_MSB:`CDD_LOW_LSB])
                       + int'(counts[`CDD_HIGH_MSB:`CDD_HIGH_LSB]) + 2;
   endfunction

   assign dccOn   = ~st_reg.ctrl[`CDD_CTRL_DCC_OFF];
   assign srcRise = srcClk & ~st_reg.srcPrev;
   assign s1Rise  = s1Out & ~st_reg.s1Prev;

   // two stages per channel, stage 2 fed by stage 1
   for (genvar c = 0; c < 2; c++)
   begin : g_chan
      // levels delayed one clock so they line up with the rise strobes
      // RQ2 stage 1 field layout
      cdd_stage u_stage1 (
         .clk       (clk),
         .rst       (rst),
         .ce        (ce),
         .restart   (st_reg.restart),
         .inRise    (srcRise),
         .inLevel   (st_reg.srcPrev),
         .bypass    (st_reg.ctrl[`CDD_CTRL_BYP_BASE + 2 * c]),
         .dccOn     (dccOn),
         .lowCode   (st_reg.divReg[4 * c][`CDD_LOW_MSB:`CDD_LOW_LSB]),
         .highCode  (st_reg.divReg[4 * c][`CDD_HIGH_MSB:`CDD_HIGH_LSB]),
         .phaseCode (st_reg.divReg[4 * c + 1][3:0]),
         .startHigh (st_reg.divReg[4 * c + 3][0]),
         .outLevel  (s1Out[c])
      );
      // RQ3 stage 2 upper nibble
      // RQ13 stage 1 clocks stage 2
      cdd_stage u_stage2 (
         .clk       (clk),
         .rst       (rst),
         .ce        (ce),
         .restart   (st_reg.restart),
         .inRise    (s1Rise[c]),
         .inLevel   (st_reg.s1Prev[c]),
         .bypass    (st_reg.ctrl[`CDD_CTRL_BYP_BASE + 2 * c + 1]),
         .dccOn     (dccOn),
         .lowCode   (st_reg.divReg[4 * c + 2][`CDD_LOW_MSB:`CDD_LOW_LSB]),
         .highCode  (st_reg.divReg[4 * c + 2][`CDD_HIGH_MSB:`CDD_HIGH_LSB]),
         .phaseCode (st_reg.divReg[4 * c + 1][7:4]),
         .startHigh (st_reg.divReg[4 * c + 3][1]),
         .outLevel  (s2Out[c])
      );
   end

   // address decode into register slots
   always_comb
   begin
      idx     = address[10:2];
      isFd    = (idx >= `CDD_IDX_DELAYED_OUTPUT_FIRST_DELAY_BYPASS) && (idx <= `CDD_IDX_DELAYED_OUTPUT_LAST_DELAY_FRACTION);
      isDiv   = 1'b0;
      fdSlot  = 4'(idx - `CDD_IDX_DELAYED_OUTPUT_FIRST_DELAY_BYPASS);
      divSlot = 3'h0;
      if ((idx >= `CDD_IDX_CHAN_A_STAGE1_COUNTS) && (idx <= `CDD_IDX_CHAN_A_START_HIGH))
      begin
         isDiv   = 1'b1;
         divSlot = 3'(idx - `CDD_IDX_CHAN_A_STAGE1_COUNTS);
      end
      else if ((idx >= `CDD_IDX_CHAN_B_STAGE1_COUNTS) && (idx <= `CDD_IDX_CHAN_B_START_HIGH))
      begin
         isDiv   = 1'b1;
         divSlot = 3'(idx - `CDD_IDX_CHAN_B_STAGE1_COUNTS) + 3'h4;
      end
   end

   // RQ8 writable bits per slot
   always_comb
   begin
      slotMask = 8'h00;
      readByte = 8'h00;
      if (isFd)
      begin
         slotMask = ((fdSlot % 4'h3) == 4'h0) ? `CDD_MASK_BYPASS : `CDD_MASK_SIX;
         readByte = st_reg.fdReg[fdSlot];
      end
      else if (isDiv)
      begin
         slotMask = (divSlot[1:0] == 2'h3) ? `CDD_MASK_SH : `CDD_MASK_FULL;
         readByte = st_reg.divReg[divSlot];
      end
      else if (idx == `CDD_IDX_CTRL)
      begin
         slotMask = `CDD_MASK_CTRL;
         readByte = {3'h0, st_reg.ctrl};
      end
      else if (idx == `CDD_IDX_STATUS)
         readByte = {2'h0, st_reg.chanOut, st_reg.stopped};
   end

   // bus slave, channel outputs and fine delay settings
   always_comb
   begin
      int d1;
      int d2;
      int periodPs;
      logic [2:0] capCode;
      logic [2:0] curCode;
      d1       = 0;
      d2       = 0;
      periodPs = 0;
      capCode  = 3'h0;
      curCode  = 3'h0;
      st_next  = st_reg;
      st_next.restart = 1'b0;
      // one wait cycle, then answer
      if ((read | write) & ~st_reg.ack)
      begin
         st_next.ack = 1'b1;
         // read data only reloads on a read
         if (read)
            st_next.rdata = {24'h000000, readByte};
      end
      else
         st_next.ack = 1'b0;
      // write lands on the edge where waitrequest is low
      if (write & st_reg.ack & byteenable[0])
      begin
         if (isFd)
            st_next.fdReg[fdSlot] = writedata[7:0] & slotMask;
         else if (isDiv)
            st_next.divReg[divSlot] = writedata[7:0] & slotMask;
         else if (idx == `CDD_IDX_CTRL)
         begin
            st_next.ctrl    = writedata[4:0] & slotMask[4:0];
            st_next.restart = writedata[`CDD_CTRL_RESTART];
         end
      end
      // edge trackers and channel outputs
      st_next.srcPrev = srcClk;
      st_next.s1Prev  = s1Out;
      // RQ6 bypassed stages pass source
      st_next.chanOut = s2Out;
      for (int k = 0; k < 4; k++)
      begin
         capCode = st_reg.fdReg[3 * k + 1][`CDD_CAP_MSB:`CDD_CAP_LSB];
         curCode = st_reg.fdReg[3 * k + 1][`CDD_CUR_MSB:`CDD_CUR_LSB];
         st_next.capCount[k] = calcCaps(capCode);
         st_next.rampUa[k]   = 11'(`CDD_RAMP_UNIT_UA * (int'(curCode) + 1));
         // RQ11 fraction assumed at most 47
         st_next.fineDelay[k] = calcDelay(capCode, curCode,
                                          st_reg.fdReg[3 * k + 2][`CDD_FRAC_MSB:0]);
         d1 = stageDiv(st_reg.ctrl[`CDD_CTRL_BYP_BASE + 2 * (k / 2)],
                       st_reg.divReg[4 * (k / 2)]);
         d2 = stageDiv(st_reg.ctrl[`CDD_CTRL_BYP_BASE + 2 * (k / 2) + 1],
                       st_reg.divReg[4 * (k / 2) + 2]);
         periodPs = d1 * d2 * SRC_PERIOD_PS;
         // RQ12 stop beyond half period
         st_next.stopped[k] = ~st_reg.fdReg[3 * k][0]
                              & ((2 * int'(st_reg.fineDelay[k])) > periodPs);
         st_next.outLvl[k]  = st_reg.chanOut[k / 2] & ~st_reg.stopped[k];
      end
   end

   // state register, frozen while ce is low
   always_ff @(posedge clk)
   begin
      if (rst)
         st_reg <= RST_STATE;
      else if (ce)
         st_reg <= st_next;
   end

   // bus handshake and registered outputs
   assign waitrequest         = (read | write) & ~st_reg.ack;
   assign readdata            = st_reg.rdata;
   assign delayedOutputFirst  = st_reg.outLvl[0];
   assign delayedOutputSecond = st_reg.outLvl[1];
   assign delayedOutputThird  = st_reg.outLvl[2];
   assign delayedOutputLast   = st_reg.outLvl[3];
   assign capCount            = st_reg.capCount;
   assign rampCurrentUa       = st_reg.rampUa;
   assign fineDelayPs         = st_reg.fineDelay;

   // delay bypass bits straight from the registers
   always_comb
   begin
      for (int k = 0; k < 4; k++)
         delayBypass[k] = st_reg.fdReg[3 * k][0];
   end
endmodule

// file: test/cdd_divider_chk.sv
// assertions on the bus and fine delay ports of the divider block
`timescale 1ns/1ps
module cdd_divider_chk (
   input wire logic             clk,
   input wire logic             rst,
   input wire logic             read,
   input wire logic             write,
   input wire logic [31:0]      readdata,
   input wire logic             waitrequest,
   input wire logic             delayedOutputFirst,
   input wire logic [3:0]       delayBypass,
   input wire logic [3:0][2:0]  capCount,
   input wire logic [3:0][10:0] rampCurrentUa,
   input wire logic [3:0][15:0] fineDelayPs
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // request phases of one bus transfer
   sequence s_req;
      (read || write) && waitrequest;
   endsequence
   sequence s_ack;
      (read || write) && !waitrequest;
   endsequence

   // bus handshake and read data
   AST_BUS_ACK: assert property (s_req |=> s_ack)
      else $error("bus request not answered after one wait cycle");
   AST_BUS_IDLE: assert property (!(read || write) |-> !waitrequest)
      else $error("wait asserted with no request");
   AST_RD_UPPER: assert property (s_ack and read |-> readdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   AST_RD_HOLD: assert property (!read |=> $stable(readdata))
      else $error("read data changed without a read");
   AST_RST_CLEAR: assert property ($fell(rst) |->
      readdata == 32'h0 && delayBypass == 4'h0 && !delayedOutputFirst)
      else $error("state not cleared by reset");
   // fine delay settings of the first delayed output stay within their documented ranges
   AST_CAP_RANGE: assert property (!$past(rst) && !$past(rst, 2) |->
      capCount[0] >= 3'h1 && capCount[0] <= 3'h4)
      else $error("capacitor count out of range");
   AST_RAMP_STEP: assert property (!$past(rst) && !$past(rst, 2) |->
      rampCurrentUa[0] % 11'hc8 == 11'h0 && rampCurrentUa[0] >= 11'hc8
      && rampCurrentUa[0] <= 11'h640)
      else $error("ramp current not a 200 uA step");
   AST_FD_FLOOR: assert property (!$past(rst) && !$past(rst, 2) |->
      fineDelayPs[0] >= 16'h154)
      else $error("fine delay below its offset floor");
endmodule

bind cdd_divider_top cdd_divider_chk chk_u (.clk(clk), .rst(rst), .read(read), .write(write),
   .readdata(readdata), .waitrequest(waitrequest), .delayedOutputFirst(delayedOutputFirst),
   .delayBypass(delayBypass), .capCount(capCount), .rampCurrentUa(rampCurrentUa),
   .fineDelayPs(fineDelayPs));

// file: test/cdd_divider_top_tb.sv
// self-checking bench for the cascaded divider block
`timescale 1ns/1ps
module cdd_divider_top_tb;
   logic             clk;
   logic             rst;
   logic             srcClk = 1'b0;
   logic [10:0]      address;
   logic             read;
   logic             write;
   logic [31:0]      writedata;
   logic [31:0]      readdata;
   logic             waitrequest;
   wire  [3:0]       outs;
   logic [3:0]       delayBypass;
   logic [3:0][2:0]  capCount;
   logic [3:0][10:0] rampCurrentUa;
   logic [3:0][15:0] fineDelayPs;
   logic [31:0]      rdVal;
   int               srcHi = 2;
   int               srcCnt = 0;
   int               errTotal = 0;
   int               samplesChecked = 0;
   localparam logic [8:0] REG_IDX [20] = '{9'h0a0, 9'h0a1, 9'h0a2, 9'h0a3, 9'h0a4, 9'h0a5,
      9'h0a6, 9'h0a7, 9'h0a8, 9'h0a9, 9'h0aa, 9'h0ab, 9'h199, 9'h19a, 9'h19b, 9'h19c,
      9'h19e, 9'h19f, 9'h1a0, 9'h1a1};
   localparam logic [7:0] REG_MASK [20] = '{8'h01, 8'h3f, 8'h3f, 8'h01, 8'h3f, 8'h3f,
      8'h01, 8'h3f, 8'h3f, 8'h01, 8'h3f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h03,
      8'hff, 8'hff, 8'hff, 8'h03};
   localparam logic [7:0] SET_VAL [20] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00,
      8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h21, 8'h00, 8'h00, 8'h00,
      8'h21, 8'h00, 8'h00, 8'h00};
   localparam logic [5:0]  FD_CODE [4] = '{6'h2a, 6'h3f, 6'h00, 6'h20};
   localparam logic [31:0] FD_CAP [4] = '{32'h2, 32'h1, 32'h4, 32'h3};
   localparam logic [31:0] FD_RAMP [4] = '{32'h258, 32'h640, 32'hc8, 32'hc8};
   localparam logic [31:0] FD_PS [4] = '{32'h1c2, 32'h154, 32'h23a, 32'h21c};

   cdd_divider_top #(.SRC_PERIOD_PS(1000)) dut_u (.clk(clk), .rst(rst), .ce(1'b1),
      .srcClk(srcClk), .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(4'h1), .readdata(readdata), .waitrequest(waitrequest),
      .delayedOutputFirst(outs[0]), .delayedOutputSecond(outs[1]),
      .delayedOutputThird(outs[2]), .delayedOutputLast(outs[3]), .delayBypass(delayBypass),
      .capCount(capCount), .rampCurrentUa(rampCurrentUa), .fineDelayPs(fineDelayPs));

   // system clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // divider input clock, four clk cycles a period, srcHi cycles high
   always @(posedge clk)
   begin
      srcCnt <= (srcCnt + 1) % 4;
      srcClk <= (srcCnt < srcHi);
   end

   task automatic giveVerdict();
      $display("comparisons %0d mismatches %0d", samplesChecked, errTotal);
      if (errTotal == 0 && samplesChecked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp)
      begin
         errTotal++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one clock with a bounded budget
   task automatic tick(inout int n);
      @(posedge clk);
      n++;
      if (n > 400)
      begin
         errTotal++;
         giveVerdict();
      end
   endtask

   // one bus transfer held until waitrequest is seen low
   task automatic busXfer(input logic wr, input logic [8:0] idx, input logic [7:0] data);
      int n;
      n = 0;
      @(posedge clk);
      address <= {idx, 2'b00};
      read <= !wr;
      write <= wr;
      writedata <= {24'h0, data};
      do tick(n); while (waitrequest !== 1'b0);
      rdVal = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic checkRegs();
      for (int i = 0; i < 20; i++)
      begin
         busXfer(1'b0, REG_IDX[i], 8'h00);
         cmpVal(rdVal, 32'h0); // reset value
         busXfer(1'b1, REG_IDX[i], 8'hff);
         busXfer(1'b0, REG_IDX[i], 8'h00);
         cmpVal(rdVal, {24'h0, REG_MASK[i]}); // field layout
         busXfer(1'b1, REG_IDX[i], SET_VAL[i]);
      end
      busXfer(1'b1, 9'h0ac, 8'hff);
      busXfer(1'b0, 9'h0ac, 8'h00);
      cmpVal(rdVal, 32'h0); // unmapped reads zero
      cmpVal({28'h0, delayBypass}, 32'hf); // bypass bits
   endtask

   task automatic checkFine();
      for (int i = 0; i < 4; i++)
      begin
         busXfer(1'b1, 9'h0a1, {2'b00, FD_CODE[i]});
         repeat (3) @(posedge clk);
         cmpVal({29'h0, capCount[0]}, FD_CAP[i]); // zero bits plus one
         cmpVal({21'h0, rampCurrentUa[0]}, FD_RAMP[i]); // current steps
         cmpVal({16'h0, fineDelayPs[0]}, FD_PS[i]); // offset at zero fraction
      end
      busXfer(1'b1, 9'h0a1, 8'h30);
      busXfer(1'b1, 9'h0a2, 8'h2f); // fraction kept within limit
      repeat (3) @(posedge clk);
      cmpVal({16'h0, fineDelayPs[0]}, 32'h1559); // range times fraction
   endtask

   // time one high and one low phase of an output
   task automatic measure(input int sel, input int expHi, input int expLo);
      int n;
      int hi;
      int lo;
      n = 0;
      hi = 0;
      lo = 0;
      while (outs[sel] !== 1'b0) tick(n);
      while (outs[sel] !== 1'b1) tick(n);
      while (outs[sel] === 1'b1) tick(hi);
      while (outs[sel] === 1'b0) tick(lo);
      cmpVal(hi, expHi);
      cmpVal(lo, expLo);
   endtask

   task automatic dutyCase(input logic [7:0] ctrl, input logic [7:0] s1, input int hiLen,
                           input int expHi, input int expLo);
      srcHi <= hiLen;
      busXfer(1'b1, 9'h199, s1);
      busXfer(1'b1, 9'h1b0, ctrl);
      repeat (60) @(posedge clk);
      measure(0, expHi, expLo);
   endtask

   // cycles until a falling edge seen after high
   task automatic waitFall(input int sel, output int n);
      n = 0;
      while (outs[sel] !== 1'b1) tick(n);
      while (outs[sel] !== 1'b0) tick(n);
   endtask

   task automatic checkPhase(input logic [7:0] sh, input logic [7:0] po, input int expClk);
      int a;
      int b;
      busXfer(1'b1, 9'h1a1, sh);
      busXfer(1'b1, 9'h19f, po);
      busXfer(1'b1, 9'h1b0, 8'h35);
      repeat (4) @(posedge clk);
      waitFall(0, a);
      waitFall(2, b);
      cmpVal(b, expClk);
   endtask

   task automatic checkStop();
      int highs;
      int lastHighs;
      highs = 0;
      lastHighs = 0;
      busXfer(1'b1, 9'h0a3, 8'h00);
      repeat (60) @(posedge clk);
      for (int i = 0; i < 40; i++)
      begin
         @(posedge clk);
         highs += (outs[1] !== 1'b0);
         lastHighs += (outs[3] === 1'b1);
      end
      cmpVal(highs, 0); // long delay stops output
      cmpVal(lastHighs, 20); // odd then even keeps half duty
      busXfer(1'b0, 9'h1b1, 8'h00);
      cmpVal(rdVal & 32'h2, 32'h2); // stop flag
   endtask

   // main sequence
   initial
   begin
      rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 11'h0;
      writedata = 32'h0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      checkRegs();
      checkFine();
      dutyCase(8'h05, 8'h21, 2, 8, 12); // counts minus one
      dutyCase(8'h04, 8'h11, 1, 8, 8); // even stage
      dutyCase(8'h00, 8'h21, 1, 20, 20); // odd then even
      checkPhase(8'h00, 8'h03, 12); // small phase value
      checkPhase(8'h01, 8'h01, 20); // start high phase
      dutyCase(8'h06, 8'h21, 1, 1, 3); // bypass keeps duty
      checkStop();
      giveVerdict();
   end
endmodule
